/* File: rtl/torque_limit_regs.vh */
// Constants for the torque limit selector
`ifndef TORQUE_LIMIT_REGS_VH
`define TORQUE_LIMIT_REGS_VH
`define TLIM_W            14
`define TLIM_MAX          14'h2710
`define TLIM_DEFAULT      14'h03e8
`define STOP_TLIM_DEFAULT 14'h0000
`define STANDSTILL_HOLD   1'b1
`define CTRL_POSITION     1'b0
`define CTRL_SPEED        1'b1
`define DD_TLIM_BYTE_HI   24
`define DD_TLIM_BYTE_LO   25
`define OP_NUM_W          8
`define OP_ENTRIES        256
`define SYNC_STAGES       2
`endif

/* File: rtl/op_limit_mem.v */
// Operation data torque limit table, registered read
`include "torque_limit_regs.vh"
module op_limit_mem #(
  parameter AW = `OP_NUM_W,
  parameter DW = `TLIM_W
) (
  input  wire          ref_clk,
  input  wire          rst_n,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_ff
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [(1<<AW)-1:0] written_ff;

  // Write port, marks entry as holding user data
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Valid flags so unwritten entries read the default limit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      written_ff <= {(1<<AW){1'b0}};
    end else if (wr_en) begin
      written_ff[wr_addr] <= 1'b1;
    end
  end

  // Registered read
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= `TLIM_DEFAULT;
    end else if (wr_en && wr_addr == rd_addr) begin
      rd_data_ff <= wr_data;
    end else begin
      rd_data_ff <= written_ff[rd_addr] ? mem[rd_addr] : `TLIM_DEFAULT;
    end
  end
endmodule // op_limit_mem

/* File: rtl/torque_limit_select.v */
// Torque limit source selection, standstill hold and control mode
`include "torque_limit_regs.vh"
// Function
// - Limit torque only while the torque limit request input is on.
// - Each operation entry holds a limit 0..10000 at 0.1 %, default 1000.
// - Standstill setting 0: apply limit selected by operation number at stop.
// - Standstill setting 1 (default): keep limit in force before stopping.
// - Loss of excitation drops any held limit, uses operation data limit.
// - Jog and homing operations use their own limit, default 1000.
// - Stop input applies stop limit; setting 0 keeps running data limit.
// - Direct data limit arrives in output bytes 24 and 25, default 1000.
// - Control mode 0 is position control, 1 speed control, default 0.
// - Position mode lets command position advance despite overload.
// - Speed mode fixes deviation; deviation alarm never raised.
module torque_limit_select #(
  parameter TW  = `TLIM_W,
  parameter AW  = `OP_NUM_W,
  parameter CW  = 16
) (
  input  wire          ref_clk,
  input  wire          rst_n,
  input  wire          torque_limit_request,
  input  wire          stop_in,
  input  wire          motor_moving,
  input  wire          excitation_on,
  input  wire          op_direct,
  input  wire          op_jog_home,
  input  wire          op_wr_en,
  input  wire [AW-1:0] op_wr_addr,
  input  wire [TW-1:0] op_wr_limit,
  input  wire [AW-1:0] op_select,
  input  wire          cfg_wr_en,
  input  wire          cfg_standstill_mode,
  input  wire [TW-1:0] cfg_jog_home_limit,
  input  wire [TW-1:0] cfg_stop_limit,
  input  wire          cfg_ctrl_mode,
  input  wire          dd_wr_en,
  input  wire [7:0]    dd_byte24,
  input  wire [7:0]    dd_byte25,
  input  wire [CW-1:0] torque_cmd,
  input  wire          deviation_over,
  output reg  [CW-1:0] torque_out_ff,
  output reg  [TW-1:0] active_limit_ff,
  output reg           limiting_ff,
  output reg           deviation_freeze_ff,
  output reg           deviation_alarm_ff,
  output reg           ctrl_mode_ff
);
  reg  [`SYNC_STAGES-1:0] req_sync_ff;
  reg  [`SYNC_STAGES-1:0] stop_sync_ff;
  reg  [TW-1:0] jog_limit_ff;
  reg  [TW-1:0] stop_limit_ff;
  reg  [TW-1:0] dd_limit_ff;
  reg           standstill_hold_ff;
  reg  [TW-1:0] held_limit_ff;
  reg           held_valid_ff;
  reg           moving_d_ff;
  wire [TW-1:0] op_limit;
  wire          req_s;
  wire          stop_s;
  wire [15:0]   dd_word;
  reg  [TW-1:0] run_limit;
  reg  [TW-1:0] nxt_limit;
  reg  [CW-1:0] limit_cmd;
  reg  [CW-1:0] nxt_torque;
  // Saturated copies of incoming limits
  wire [TW-1:0] op_wr_sat;
  wire [TW-1:0] jog_sat;
  wire [TW-1:0] stop_sat;
  wire [TW-1:0] dd_sat;
  wire [CW-1:0] limit_wide;

  // Operation data table
  op_limit_mem #(.AW(AW), .DW(TW)) u_op_mem (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .wr_en      (op_wr_en),
    .wr_addr    (op_wr_addr),
    .wr_data    (op_wr_sat),
    .rd_addr    (op_select),
    .rd_data_ff (op_limit)
  );

  // Pin inputs pass two flops before use
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_ff  <= {`SYNC_STAGES{1'b0}};
      stop_sync_ff <= {`SYNC_STAGES{1'b0}};
    end else begin
      req_sync_ff  <= {req_sync_ff[0], torque_limit_request};
      stop_sync_ff <= {stop_sync_ff[0], stop_in};
    end
  end
  assign req_s  = req_sync_ff[1];
  assign stop_s = stop_sync_ff[1];

  // Byte 24 taken as high byte of the direct limit word
  assign dd_word = {dd_byte24, dd_byte25};

  // Out-of-range settings saturate to the maximum, never wrap
  assign op_wr_sat = (op_wr_limit > `TLIM_MAX) ? `TLIM_MAX : op_wr_limit;
  assign jog_sat   = (cfg_jog_home_limit > `TLIM_MAX) ? `TLIM_MAX : cfg_jog_home_limit;
  assign stop_sat  = (cfg_stop_limit > `TLIM_MAX) ? `TLIM_MAX : cfg_stop_limit;
  // Word is 16 bits wide, so compare before cutting to the limit width
  assign dd_sat    = (dd_word > {2'b00, `TLIM_MAX}) ? `TLIM_MAX : dd_word[TW-1:0];

  // Jog and homing limit, loaded by the settings strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      jog_limit_ff <= `TLIM_DEFAULT;
    end else if (cfg_wr_en) begin
      jog_limit_ff <= jog_sat;
    end
  end

  // Stop limit; zero means keep the running operation limit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_limit_ff <= `STOP_TLIM_DEFAULT;
    end else if (cfg_wr_en) begin
      stop_limit_ff <= stop_sat;
    end
  end

  // Standstill policy and control mode share the same strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      standstill_hold_ff <= `STANDSTILL_HOLD;
      ctrl_mode_ff       <= `CTRL_POSITION;
    end else if (cfg_wr_en) begin
      standstill_hold_ff <= cfg_standstill_mode;
      ctrl_mode_ff       <= cfg_ctrl_mode;
    end
  end

  // Direct limit taken from each cyclic data write
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dd_limit_ff <= `TLIM_DEFAULT;
    end else if (dd_wr_en) begin
      dd_limit_ff <= dd_sat;
    end
  end

  // Source choice by operation type; stop input overrides when nonzero
  // Priority: no excitation, standstill, nonzero stop limit, then source
  always @* begin
    if (op_direct) begin
      run_limit = dd_limit_ff;
    end else if (op_jog_home) begin
      run_limit = jog_limit_ff;
    end else begin
      run_limit = op_limit;
    end
    nxt_limit = run_limit;
    if (stop_s && stop_limit_ff != `STOP_TLIM_DEFAULT) begin
      nxt_limit = stop_limit_ff;
    end
    if (!excitation_on) begin
      nxt_limit = op_limit;
    end else if (!motor_moving && held_valid_ff && standstill_hold_ff) begin
      nxt_limit = held_limit_ff;
    end else if (!motor_moving && !standstill_hold_ff) begin
      nxt_limit = op_limit;
    end
  end

  // Capture the running limit on the moving-to-stopped edge
  // Captures the registered limit, so a source change in the last moving
  // cycle is missed; sources should settle before the motor stops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_limit_ff <= `TLIM_DEFAULT;
      held_valid_ff <= 1'b0;
      moving_d_ff   <= 1'b0;
    end else begin
      moving_d_ff <= motor_moving;
      if (!excitation_on || motor_moving) begin
        held_valid_ff <= 1'b0;
      end
      if (excitation_on && moving_d_ff && !motor_moving) begin
        held_limit_ff <= active_limit_ff;
        held_valid_ff <= 1'b1;
      end
    end
  end

  // Limit and command share the 0.1 % unit, so only widening is needed
  assign limit_wide = {{(CW-TW){1'b0}}, nxt_limit};

  // Clamp only while the synchronised request is on
  always @* begin
    limit_cmd = limit_wide;
    if (torque_cmd > limit_cmd && req_s) begin
      nxt_torque = limit_cmd;
    end else begin
      nxt_torque = torque_cmd;
    end
  end

  // Limit, torque and request status outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_limit_ff <= `TLIM_DEFAULT;
      torque_out_ff   <= {CW{1'b0}};
      limiting_ff     <= 1'b0;
    end else begin
      active_limit_ff <= nxt_limit;
      torque_out_ff   <= nxt_torque;
      limiting_ff     <= req_s;
    end
  end

  // Speed mode freezes the deviation, so its alarm is masked there;
  // position mode never holds back the command position
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deviation_freeze_ff <= 1'b0;
      deviation_alarm_ff  <= 1'b0;
    end else begin
      deviation_freeze_ff <= (ctrl_mode_ff == `CTRL_SPEED);
      deviation_alarm_ff  <= deviation_over && (ctrl_mode_ff == `CTRL_POSITION);
    end
  end
endmodule // torque_limit_select

/* File: sim/torque_limit_select_checker.sv */
// Port-level assertions for the torque limit selector
module torque_limit_select_checker #(
  parameter CW = 16,
  parameter TW = 14
) (
  input logic          ref_clk,
  input logic          rst_n,
  input logic          torque_limit_request,
  input logic          cfg_wr_en,
  input logic          cfg_ctrl_mode,
  input logic [CW-1:0] torque_cmd,
  input logic [CW-1:0] torque_out_ff,
  input logic [TW-1:0] active_limit_ff,
  input logic          limiting_ff,
  input logic          deviation_freeze_ff,
  input logic          deviation_alarm_ff,
  input logic          ctrl_mode_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Five samples cover the two sync flops plus the output register
  sequence s_req_on; torque_limit_request [*5]; endsequence
  sequence s_req_off; !torque_limit_request [*5]; endsequence
  a_req_enable: assert property (s_req_on |-> limiting_ff)
    else $error("limiting not on");
  a_req_disable: assert property (s_req_off |-> !limiting_ff)
    else $error("limiting not off");
  a_no_clamp: assert property (!limiting_ff [*2] |-> torque_out_ff == $past(torque_cmd))
    else $error("torque changed while unlimited");
  a_clamp_limit: assert property (limiting_ff && $past(limiting_ff) && $stable(active_limit_ff)
    |-> torque_out_ff <= {{(CW-TW){1'b0}}, active_limit_ff})
    else $error("torque above limit");
  a_limit_range: assert property (active_limit_ff <= 14'h2710)
    else $error("limit out of range");
  a_mode_load: assert property (cfg_wr_en |=> ctrl_mode_ff == $past(cfg_ctrl_mode))
    else $error("mode not loaded");
  a_mode_hold: assert property (!cfg_wr_en |=> $stable(ctrl_mode_ff))
    else $error("mode changed without write");
  a_freeze_follow: assert property (deviation_freeze_ff == $past(ctrl_mode_ff))
    else $error("freeze does not follow mode");
  a_alarm_gate: assert property (deviation_freeze_ff && ctrl_mode_ff |-> !deviation_alarm_ff)
    else $error("alarm raised in speed mode");
endmodule // torque_limit_select_checker

bind torque_limit_select torque_limit_select_checker #(.CW(CW), .TW(TW)) u_chk (.ref_clk,
  .rst_n, .torque_limit_request, .cfg_wr_en, .cfg_ctrl_mode, .torque_cmd, .torque_out_ff,
  .active_limit_ff, .limiting_ff, .deviation_freeze_ff, .deviation_alarm_ff, .ctrl_mode_ff);

/* File: sim/host_ctrl.sv */
// Host controller model writing limit table, settings and direct data
module host_ctrl (
  input  logic        ref_clk,
  output logic        op_wr_en = 1'b0,
  output logic [7:0]  op_wr_addr = 8'h00,
  output logic [13:0] op_wr_limit = 14'h0000,
  output logic        cfg_wr_en = 1'b0,
  output logic        cfg_standstill_mode = 1'b1,
  output logic [13:0] cfg_jog_home_limit = 14'h03e8,
  output logic [13:0] cfg_stop_limit = 14'h0000,
  output logic        cfg_ctrl_mode = 1'b0,
  output logic        dd_wr_en = 1'b0,
  output logic [7:0]  dd_byte24 = 8'h00,
  output logic [7:0]  dd_byte25 = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle strobe; data turns stale-inverse after, so a late sample shows
  task automatic op_wr(input logic [7:0] a, input logic [13:0] d);
    @(negedge ref_clk);
    {op_wr_en, op_wr_addr, op_wr_limit} = {1'b1, a, d};
    @(negedge ref_clk);
    {op_wr_en, op_wr_limit} = {1'b0, ~d};
  endtask
  task automatic cfg_wr(input logic m, s, input logic [13:0] j, t);
    @(negedge ref_clk);
    {cfg_wr_en, cfg_ctrl_mode, cfg_standstill_mode} = {1'b1, m, s};
    {cfg_jog_home_limit, cfg_stop_limit} = {j, t};
    @(negedge ref_clk);
    {cfg_wr_en, cfg_jog_home_limit, cfg_stop_limit} = {1'b0, ~j, ~t};
  endtask
  // Direct word is high byte then low byte
  task automatic dd_wr(input logic [7:0] hi, lo);
    @(negedge ref_clk);
    {dd_wr_en, dd_byte24, dd_byte25} = {1'b1, hi, lo};
    @(negedge ref_clk);
    {dd_wr_en, dd_byte24, dd_byte25} = {1'b0, ~hi, ~lo};
  endtask
endmodule // host_ctrl

/* File: sim/test_torque_limit_select.sv */
// Self-checking bench for the torque limit selector
module test_torque_limit_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rst_n = 1'b0, torque_limit_request = 1'b0, stop_in = 1'b0;
  logic        motor_moving = 1'b1, excitation_on = 1'b1, op_direct = 1'b0;
  logic        op_jog_home = 1'b0, deviation_over = 1'b0;
  logic [7:0]  op_select = 8'h05;
  logic [15:0] torque_cmd = 16'h0fff;
  wire         op_wr_en, cfg_wr_en, dd_wr_en, cfg_standstill_mode, cfg_ctrl_mode;
  wire  [7:0]  op_wr_addr, dd_byte24, dd_byte25;
  wire  [13:0] op_wr_limit, cfg_jog_home_limit, cfg_stop_limit, active_limit_ff;
  wire  [15:0] torque_out_ff;
  wire         limiting_ff, deviation_freeze_ff, deviation_alarm_ff, ctrl_mode_ff;
  int          errors = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  host_ctrl h (.ref_clk, .op_wr_en, .op_wr_addr, .op_wr_limit, .cfg_wr_en, .cfg_standstill_mode,
    .cfg_jog_home_limit, .cfg_stop_limit, .cfg_ctrl_mode, .dd_wr_en, .dd_byte24, .dd_byte25);
  torque_limit_select DUT (.ref_clk, .rst_n, .torque_limit_request, .stop_in, .motor_moving,
    .excitation_on, .op_direct, .op_jog_home, .op_wr_en, .op_wr_addr, .op_wr_limit, .op_select,
    .cfg_wr_en, .cfg_standstill_mode, .cfg_jog_home_limit, .cfg_stop_limit, .cfg_ctrl_mode,
    .dd_wr_en, .dd_byte24, .dd_byte25, .torque_cmd, .deviation_over, .torque_out_ff,
    .active_limit_ff, .limiting_ff, .deviation_freeze_ff, .deviation_alarm_ff, .ctrl_mode_ff);
  task automatic chk_val(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, got);
    chk_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  // Longest path is pin sync plus output register, three edges; four leaves margin
  task automatic settle;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic end_of_test;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    settle;
    chk_val("default limit", 16'h03e8, active_limit_ff);
    chk_bit("mode", 1'b0, ctrl_mode_ff);
    h.op_wr(8'h05, 14'h00fa);
    h.op_wr(8'h06, 14'h3fff);
    settle;
    chk_val("entry five", 16'h00fa, active_limit_ff);
    op_select = 8'h06;
    settle;
    chk_val("saturated entry", 16'h2710, active_limit_ff);
    op_select = 8'h05;
    h.cfg_wr(1'b0, 1'b1, 14'h012c, 14'h0000);
    op_jog_home = 1'b1;
    settle;
    chk_val("jog limit", 16'h012c, active_limit_ff);
    op_jog_home = 1'b0;
    h.dd_wr(8'h01, 8'hf4);
    op_direct = 1'b1;
    settle;
    chk_val("direct limit", 16'h01f4, active_limit_ff);
    stop_in = 1'b1;
    settle;
    chk_val("stop keeps limit", 16'h01f4, active_limit_ff);
    h.cfg_wr(1'b0, 1'b1, 14'h012c, 14'h02bc);
    settle;
    chk_val("stop limit", 16'h02bc, active_limit_ff);
    {stop_in, op_direct} = 2'b00;
    h.cfg_wr(1'b0, 1'b1, 14'h012c, 14'h0000);
    settle;
    motor_moving = 1'b0;
    settle;
    op_select = 8'h06;
    settle;
    chk_val("held limit", 16'h00fa, active_limit_ff);
    excitation_on = 1'b0;
    settle;
    chk_val("unexcited limit", 16'h2710, active_limit_ff);
    {excitation_on, motor_moving} = 2'b11;
    h.cfg_wr(1'b0, 1'b0, 14'h012c, 14'h0000);
    motor_moving = 1'b0;
    settle;
    op_select = 8'h05;
    settle;
    chk_val("follow select", 16'h00fa, active_limit_ff);
    {motor_moving, torque_limit_request} = 2'b11;
    settle;
    chk_bit("limiting", 1'b1, limiting_ff);
    chk_val("clamped torque", 16'h00fa, torque_out_ff);
    torque_cmd = 16'h0064;
    settle;
    chk_val("torque under limit", 16'h0064, torque_out_ff);
    torque_cmd = 16'h0fff;
    torque_limit_request = 1'b0;
    settle;
    chk_val("free torque", 16'h0fff, torque_out_ff);
    deviation_over = 1'b1;
    h.cfg_wr(1'b1, 1'b1, 14'h012c, 14'h0000);
    settle;
    chk_bit("freeze", 1'b1, deviation_freeze_ff);
    chk_bit("speed alarm", 1'b0, deviation_alarm_ff);
    // Mid-run reset restores defaults and forgets the table
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    settle;
    chk_val("reset limit", 16'h03e8, active_limit_ff);
    chk_bit("reset mode", 1'b0, ctrl_mode_ff);
    h.cfg_wr(1'b0, 1'b1, 14'h012c, 14'h0000);
    settle;
    chk_bit("position alarm", 1'b1, deviation_alarm_ff);
    chk_bit("no freeze", 1'b0, deviation_freeze_ff);
    end_of_test;
  end
  // Hang guard
  initial begin
    #200us;
    errors++;
    end_of_test;
  end
endmodule // test_torque_limit_select
